// ===== core/adcsf_status.sv
//
// Behaviour
// RQ1: 8-bit status register combining converter and interface status, reset value 0x80.
// RQ2: with append enabled, status byte follows the data word on each data read.
// RQ3: ready flag drives data-out/ready pin while chip select low and no read shifts.
// RQ4: ready goes low when a new result is stored; high means still pending.
// RQ5: in calibration, ready goes low when the calibration result is stored.
// RQ6: reading the data register returns ready to high.
// RQ7: range fault bit 6 set on overrange or underrange, otherwise zero.
// RQ8: overrange saturates stored result to all ones, underrange to all zeros.
// RQ9: range fault updates only on result write, clears at next clean result.
// RQ10: write-check fault bit 5 set when a register write fails its CRC.
// RQ11: host checks CRC of read data itself; device flags no read CRC failure.
// RQ12: reading the status register clears the write-check fault bit.
// RQ13: corruption bit 4 set when register content differs from checked value.
// RQ14: host enables integrity check; corruption bit clears only when enable clears.
// RQ15: bits 3:0 give channel of the result now held in the data register.
// RQ16: channel tag is plain binary channel index, 0x0 through 0xF.
// RQ17: status bits are read-only; host writes to the status address are ignored.
`timescale 1ns/100ps
`include "adcsf_map.svh"
module adcsf_status (
  // system clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // converter datapath events
  input  wire adcsf_pkg::adcsf_res_t  res_i,
  input  wire logic                   cal_done_i,
  input  wire logic                   crc_fail_i,
  input  wire logic                   integ_mismatch_i,
  // interface mode settings
  input  wire logic                   append_stat_i,
  input  wire logic                   reg_check_en_i,
  // register contents to the rest of the device
  output adcsf_pkg::adcsf_stat_t      status_o,
  output logic [`ADCSF_DATA_W-1:0]    data_reg_o,
  // serial link pins
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   din,
  output logic                        dout_rdy_o,
  output logic                        dout_rdy_oe
);

  // ---------------------------------------------------------------------
  // system domain: status register and data register
  // ---------------------------------------------------------------------
  adcsf_pkg::adcsf_stat_t  stat_ff;
  adcsf_pkg::adcsf_stat_t  nxt_stat;
  logic [`ADCSF_DATA_W-1:0] data_ff;
  adcsf_pkg::adcsf_snap_t  snap_ff;

  logic                    rd_data_tgl_ff;
  logic                    rd_stat_tgl_ff;
  logic                    lk_active_ff;
  logic [2:0]              to_sys;
  logic [2:0]              to_sys_q;
  logic                    rd_data_seen_ff;
  logic                    rd_stat_seen_ff;
  logic                    rd_data_evt;
  logic                    rd_stat_evt;
  logic                    link_busy;

  // toggles from the link and its busy level cross into sys_clk here
  assign to_sys = {lk_active_ff, rd_stat_tgl_ff, rd_data_tgl_ff};

  adcsf_sync2 #(
    .W(3)
  ) u_to_sys (
    .clk (sys_clk),
    .rst (rst),
    .d   (to_sys),
    .q   (to_sys_q)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_seen_ff <= 1'b0;
      rd_stat_seen_ff <= 1'b0;
    end else begin
      rd_data_seen_ff <= to_sys_q[0];
      rd_stat_seen_ff <= to_sys_q[1];
    end
  end

  assign rd_data_evt = to_sys_q[0] ^ rd_data_seen_ff;
  assign rd_stat_evt = to_sys_q[1] ^ rd_stat_seen_ff;
  assign link_busy   = to_sys_q[2];

  // next status value; rdy_n clears follow its data-read set and the crc_err set follows its clear, so those win, but a low reg_check_en_i keeps reg_err clear
  always_comb begin
    nxt_stat = stat_ff;
    // host read of the data register releases the ready flag
    if (rd_data_evt) begin
      nxt_stat.rdy_n = 1'b1; // RQ6
    end
    if (res_i.wr) begin
      nxt_stat.rdy_n     = 1'b0; // RQ4
      nxt_stat.range_err = res_i.over | res_i.under; // RQ7 RQ9
      nxt_stat.chan      = res_i.chan; // RQ15 RQ16
    end
    if (cal_done_i) begin
      nxt_stat.rdy_n = 1'b0; // RQ5
    end
    if (rd_stat_evt) begin
      nxt_stat.crc_err = 1'b0; // RQ12
    end
    // only write CRC failures arrive here; read CRC is the host's job
    if (crc_fail_i) begin
      nxt_stat.crc_err = 1'b1; // RQ10 RQ11
    end
    if (!reg_check_en_i) begin
      nxt_stat.reg_err = 1'b0; // RQ14
    end else if (integ_mismatch_i) begin
      nxt_stat.reg_err = 1'b1; // RQ13
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= adcsf_pkg::adcsf_stat_t'(`ADCSF_STAT_RESET); // RQ1
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // stored result saturates at the rails
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_ff <= `ADCSF_DATA_MIN;
    end else if (res_i.wr) begin
      if (res_i.over) begin
        data_ff <= `ADCSF_DATA_MAX; // RQ8
      end else if (res_i.under) begin
        data_ff <= `ADCSF_DATA_MIN; // RQ8
      end else begin
        data_ff <= res_i.data;
      end
    end
  end

  // snapshot frozen while a frame clocks, so the link sees stable words;
  // the link needs them only after the command byte, long after the freeze
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snap_ff <= '0;
    end else if (!link_busy) begin
      snap_ff.append <= append_stat_i;
      snap_ff.data   <= data_ff;
      snap_ff.stat   <= stat_ff;
    end
  end

  assign status_o   = stat_ff;
  assign data_reg_o = data_ff;

  // ---------------------------------------------------------------------
  // link domain: runs on sclk; frame logic cleared between frames by chip select, read toggles by rst only
  // ---------------------------------------------------------------------
  adcsf_pkg::adcsf_lk_state_t lk_state_ff;
  logic [`ADCSF_CNT_W-1:0]    cnt_ff;
  logic [`ADCSF_CMD_W-1:0]    cmd_ff;
  logic [`ADCSF_SHIFT_W-1:0]  sh_ff;
  logic [`ADCSF_CNT_W-1:0]    rem_ff;
  logic                       lk_rst;
  logic [`ADCSF_CMD_W-1:0]    cmd_full;
  logic                       cmd_is_rd;
  logic [`ADCSF_ADDR_W-1:0]   cmd_addr;

  // the link clock stops outside frames, so deselect ends every frame
  assign lk_rst    = rst | cs_n;
  assign cmd_full  = {cmd_ff[`ADCSF_CMD_W-2:0], din};
  assign cmd_is_rd = ~cmd_full[`ADCSF_CMD_WEN] & cmd_full[`ADCSF_CMD_RD];
  assign cmd_addr  = cmd_full[`ADCSF_ADDR_W-1:0];

  // level seen by sys_clk to freeze the snapshot
  always_ff @(posedge sclk or posedge lk_rst) begin
    if (lk_rst) begin
      lk_active_ff <= 1'b0;
    end else begin
      lk_active_ff <= 1'b1;
    end
  end

  // command byte, then read shifting
  always_ff @(posedge sclk or posedge lk_rst) begin
    if (lk_rst) begin
      lk_state_ff <= adcsf_pkg::ADCSF_LK_CMD;
      cnt_ff      <= '0;
      cmd_ff      <= '0;
      sh_ff       <= '0;
      rem_ff      <= '0;
    end else begin
      case (lk_state_ff)
        adcsf_pkg::ADCSF_LK_CMD: begin
          cmd_ff <= cmd_full;
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == `ADCSF_CMD_LAST) begin
            cnt_ff <= '0;
            // writes, including to the status address, change nothing here
            if (cmd_is_rd && cmd_addr == `ADCSF_ADDR_STATUS) begin
              sh_ff       <= {snap_ff.stat, `ADCSF_DATA_MIN};
              rem_ff      <= `ADCSF_LEN_STAT;
              lk_state_ff <= adcsf_pkg::ADCSF_LK_READ;
            end else if (cmd_is_rd && cmd_addr == `ADCSF_ADDR_DATA) begin
              sh_ff <= {snap_ff.data, snap_ff.stat}; // RQ2
              if (snap_ff.append) begin
                rem_ff <= `ADCSF_LEN_DATA_STAT; // RQ2
              end else begin
                rem_ff <= `ADCSF_LEN_DATA;
              end
              lk_state_ff <= adcsf_pkg::ADCSF_LK_READ;
            end else begin
              lk_state_ff <= adcsf_pkg::ADCSF_LK_CMD; // RQ17
            end
          end
        end
        adcsf_pkg::ADCSF_LK_READ: begin
          sh_ff  <= {sh_ff[`ADCSF_SHIFT_W-2:0], 1'b0};
          rem_ff <= rem_ff - 1'b1;
          if (rem_ff == `ADCSF_CNT_W'(1)) begin
            lk_state_ff <= adcsf_pkg::ADCSF_LK_DONE;
          end
        end
        adcsf_pkg::ADCSF_LK_DONE: begin
          // further commands in the same frame start a new byte
          cmd_ff      <= cmd_full;
          cnt_ff      <= `ADCSF_CNT_W'(1);
          lk_state_ff <= adcsf_pkg::ADCSF_LK_CMD;
        end
        default: begin
          lk_state_ff <= adcsf_pkg::ADCSF_LK_CMD;
        end
      endcase
    end
  end

  // read events as toggles; they must survive deselect, so only rst clears
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rd_data_tgl_ff <= 1'b0;
      rd_stat_tgl_ff <= 1'b0;
    end else if (!cs_n && lk_state_ff == adcsf_pkg::ADCSF_LK_CMD &&
                 cnt_ff == `ADCSF_CMD_LAST && cmd_is_rd) begin
      if (cmd_addr == `ADCSF_ADDR_DATA) begin
        rd_data_tgl_ff <= ~rd_data_tgl_ff; // RQ6
      end
      if (cmd_addr == `ADCSF_ADDR_STATUS) begin
        rd_stat_tgl_ff <= ~rd_stat_tgl_ff; // RQ12
      end
    end
  end

  // pin shows read data while shifting, otherwise the live ready flag
  assign dout_rdy_oe = ~cs_n; // RQ3
  assign dout_rdy_o  = (lk_state_ff == adcsf_pkg::ADCSF_LK_READ) ?
                       sh_ff[`ADCSF_SHIFT_W-1] : stat_ff.rdy_n; // RQ3

endmodule : adcsf_status

// ===== core/adcsf_map.svh
`ifndef ADCSF_MAP_SVH
`define ADCSF_MAP_SVH

// register map
`define ADCSF_ADDR_W        6
`define ADCSF_ADDR_STATUS   6'h00
`define ADCSF_ADDR_DATA     6'h04

// status register layout and reset value
`define ADCSF_STAT_W        8
`define ADCSF_STAT_RESET    8'h80
`define ADCSF_BIT_RDY       7
`define ADCSF_BIT_RANGE     6
`define ADCSF_BIT_CRC       5
`define ADCSF_BIT_REG       4
`define ADCSF_CHAN_W        4

// conversion result
`define ADCSF_DATA_W        24
`define ADCSF_DATA_MAX      24'hffffff
`define ADCSF_DATA_MIN      24'h000000

// serial command byte: bit 7 must be 0, bit 6 selects read, bits 5:0 address
`define ADCSF_CMD_W         8
`define ADCSF_CMD_WEN       7
`define ADCSF_CMD_RD        6
`define ADCSF_CNT_W         6
`define ADCSF_CMD_LAST      6'h07
`define ADCSF_LEN_STAT      6'h08
`define ADCSF_LEN_DATA      6'h18
`define ADCSF_LEN_DATA_STAT 6'h20
`define ADCSF_SHIFT_W       32

`endif

// ===== core/adcsf_pkg.sv
package adcsf_pkg;

  // status byte, msb first as it sits in the register
  typedef struct packed {
    logic       rdy_n;
    logic       range_err;
    logic       crc_err;
    logic       reg_err;
    logic [3:0] chan;
  } adcsf_stat_t;

  // one result written by the converter datapath
  typedef struct packed {
    logic        wr;
    logic        over;
    logic        under;
    logic [3:0]  chan;
    logic [23:0] data;
  } adcsf_res_t;

  // read snapshot handed to the link domain
  typedef struct packed {
    logic        append;
    logic [23:0] data;
    adcsf_stat_t stat;
  } adcsf_snap_t;

  typedef enum logic [1:0] {
    ADCSF_LK_CMD  = 2'b00,
    ADCSF_LK_READ = 2'b01,
    ADCSF_LK_DONE = 2'b10
  } adcsf_lk_state_t;

endpackage : adcsf_pkg

// ===== core/adcsf_sync2.sv
`timescale 1ns/100ps
module adcsf_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : adcsf_sync2

// ===== testbench/adcsf_checker.sv
`timescale 1ns/100ps
module adcsf_checker (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // converter events and mode
  input wire adcsf_pkg::adcsf_res_t  res_i,
  input wire logic                   cal_done_i,
  input wire logic                   crc_fail_i,
  input wire logic                   reg_check_en_i,
  // register outputs, chip select and pin enable
  input wire adcsf_pkg::adcsf_stat_t status_o,
  input wire logic [23:0]            data_reg_o,
  input wire logic                   cs_n,
  input wire logic                   dout_rdy_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> status_o == 8'h80; endproperty
  a_rst: assert property (p_rst) else $error("status not 80 after reset");
  property p_oe; dout_rdy_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("pin enable not tied to select");
  property p_rdy; res_i.wr |=> !status_o.rdy_n; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not low after result");
  property p_cal; cal_done_i |=> !status_o.rdy_n; endproperty
  a_cal: assert property (p_cal) else $error("ready not low after calibration");
  property p_rng; res_i.wr |=> status_o.range_err == ($past(res_i.over) || $past(res_i.under));
  endproperty
  a_rng: assert property (p_rng) else $error("range flag wrong");
  property p_ovr; res_i.wr && res_i.over |=> data_reg_o == 24'hffffff; endproperty
  a_ovr: assert property (p_ovr) else $error("overrange not saturated");
  property p_hold; !res_i.wr |=> $stable(status_o.range_err); endproperty
  a_hold: assert property (p_hold) else $error("range flag moved without result");
  property p_crc; crc_fail_i |=> status_o.crc_err; endproperty
  a_crc: assert property (p_crc) else $error("write check flag not set");
  property p_reg; !reg_check_en_i |=> !status_o.reg_err; endproperty
  a_reg: assert property (p_reg) else $error("corruption flag kept");
  property p_chan; res_i.wr |=> status_o.chan == $past(res_i.chan); endproperty
  a_chan: assert property (p_chan) else $error("channel tag wrong");
endmodule : adcsf_checker

bind adcsf_status adcsf_checker u_adcsf_checker (
  .sys_clk(sys_clk), .rst(rst), .res_i(res_i), .cal_done_i(cal_done_i),
  .crc_fail_i(crc_fail_i), .reg_check_en_i(reg_check_en_i), .status_o(status_o),
  .data_reg_o(data_reg_o), .cs_n(cs_n), .dout_rdy_oe(dout_rdy_oe));

// ===== testbench/adcsf_host.sv
`timescale 1ns/100ps
module adcsf_host (
  // link pins driven by the host
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  // combined data-out and ready pin
  input  wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // clock stands still outside frames; din toggles where it carries nothing
  task automatic xfer(input logic [7:0] cmd, input int n, output logic rdy,
                      output logic [31:0] v);
    v = '0;
    cs_n = 1'b0;
    #40;
    rdy = dout;
    for (int i = 0; i < 8 + n; i++) begin
      sclk = 1'b0;
      din = (i < 8) ? cmd[7 - i] : ~din;
      #32;
      if (i >= 8)
        v = {v[30:0], dout};
      sclk = 1'b1;
      #32;
    end
    cs_n = 1'b1;
    din = ~din;
    #80;
  endtask : xfer
endmodule : adcsf_host

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  adcsf_pkg::adcsf_res_t  res_i = '0;
  adcsf_pkg::adcsf_res_t  r;
  logic [2:0]             evt = '0;
  logic                   append_stat_i = 1'b0;
  logic                   reg_check_en_i = 1'b0;
  adcsf_pkg::adcsf_stat_t status_o;
  adcsf_pkg::adcsf_stat_t e_stat;
  logic [23:0]            data_reg_o;
  logic [23:0]            e_data;
  logic                   sclk, cs_n, din, dout_rdy_o, dout_rdy_oe, pin;
  logic [31:0]            rd;
  int                     seed = 32'h7cee5858;
  int                     bad_count = 0;
  int                     total_checks = 0;
  always #10 sys_clk = ~sys_clk;
  adcsf_status u_adcsf_status (.sys_clk(sys_clk), .rst(rst), .res_i(res_i),
    .cal_done_i(evt[2]), .crc_fail_i(evt[1]), .integ_mismatch_i(evt[0]),
    .append_stat_i(append_stat_i), .reg_check_en_i(reg_check_en_i), .status_o(status_o),
    .data_reg_o(data_reg_o), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe));
  adcsf_host u_adcsf_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_rdy_o));
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // one-cycle event pulse, then settle
  task automatic ev(input adcsf_pkg::adcsf_res_t rr, input logic [2:0] e);
    @(posedge sys_clk);
    res_i <= rr;
    evt <= e;
    @(posedge sys_clk);
    res_i <= '0;
    evt <= '0;
    @(posedge sys_clk);
    #1;
  endtask : ev
  task automatic xf(input logic [7:0] c, input int n);
    u_adcsf_host.xfer(c, n, pin, rd);
    chk({31'h0, e_stat.rdy_n}, {31'h0, pin}, "ready pin");
  endtask : xf
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    e_stat = 8'h80;
    e_data = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(e_stat, status_o, "status reset");
    chk(e_data, data_reg_o, "data reset");
    for (int i = 0; i < 16; i++) begin
      r = '0;
      r.data = 24'($random(seed));
      r.chan = i[3:0];
      r.over = (i % 4 == 1);
      r.under = (i % 4 == 2);
      r.wr = 1'b1;
      append_stat_i <= i[1];
      ev(r, 3'h0);
      e_data = r.over ? 24'hffffff : (r.under ? 24'h000000 : r.data);
      e_stat = {1'b0, r.over | r.under, e_stat.crc_err, e_stat.reg_err, r.chan};
      chk(e_stat, status_o, "status after result");
      chk(e_data, data_reg_o, "stored result");
      if (i[0]) begin
        xf(8'h44, i[1] ? 32 : 24);
        chk(i[1] ? {e_data, e_stat} : {8'h00, e_data}, rd, "data read");
        e_stat.rdy_n = 1'b1;
      end else begin
        xf(8'h40, 8);
        chk(e_stat, rd, "status read");
      end
      chk(e_stat, status_o, "status after read");
    end
    $display("test results done");
    ev('0, 3'h2);
    e_stat.crc_err = 1'b1;
    chk(e_stat, status_o, "write check flag");
    xf(8'h40, 8);
    chk(e_stat, rd, "status read with fault");
    e_stat.crc_err = 1'b0;
    chk(e_stat, status_o, "write check cleared");
    $display("test write check done");
    ev('0, 3'h4);
    e_stat.rdy_n = 1'b0;
    chk(e_stat, status_o, "calibration ready");
    xf(8'h00, 0);
    xf(8'h47, 0);
    chk(e_stat, status_o, "ignored commands");
    $display("test calibration done");
    reg_check_en_i <= 1'b1;
    ev('0, 3'h1);
    e_stat.reg_err = 1'b1;
    chk(e_stat, status_o, "corruption set");
    reg_check_en_i <= 1'b0;
    ev('0, 3'h0);
    e_stat.reg_err = 1'b0;
    chk(e_stat, status_o, "corruption cleared");
    $display("test integrity done");
    end_sim();
  end
endmodule : tb
